// *** src/cpu_instruction_decode_core.sv ***
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Instruction words are thirteen bits wide.
// - One cycle is two oscillator periods.
// - Program counter writes take two cycles.
// - Branches, returns, taken skips may take two.
// - Config bit nine picks jump/call length.
// - Configuration word unreachable by running code.
// - Any register bit set, cleared, tested.
// - Control registers use ordinary register operands.
// - Fields: register, bit position, literal.
// - Idle does nothing; decimal adjust sets carry.
// - Halt and watchdog clear update timeout flags.
// - Unmask and mask interrupts, flags untouched.
// - Returns pop stack; irq return unmasks.
// - Accumulator to/from control register.
// - Store accumulator to register, flags untouched.
// - Clear accumulator or register, zero flag only.
// - Subtract register minus accumulator, three flags.
// - Decrement register into accumulator or register.
// - OR, AND, XOR with destination bit.
module cpu_instruction_decode_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic [12:0] config_word,
  input wire logic [12:0] instr_word,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] ctrl_rdata,
  output logic instr_fetch,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic [3:0] ctrl_addr,
  output logic [7:0] ctrl_wdata,
  output logic ctrl_we,
  output logic [7:0] accum,
  output core_pkg::status_t status,
  output logic irq_enable,
  output logic wdt_clear,
  output logic osc_stop,
  output logic stack_pop,
  output logic call_push,
  output logic jump_take,
  output logic [9:0] jump_target,
  output logic skip_next,
  output logic cycle_long
);
  core_pkg::core_state_t state_reg; // Sequencer state
  core_pkg::core_state_t state_next;
  core_pkg::decoded_t dec_now; // Decode of the word on the bus
  core_pkg::decoded_t dec_reg; // Instruction under execution
  logic cfg_two_reg; // Captured jump/call cycle select
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic exec; // Second half of the first cycle
  logic to_r; // Result goes to the register file
  logic to_a; // Result goes to the accumulator
  logic zero_upd; // Zero flag is refreshed
  logic pc_write; // Result lands in the program counter
  logic branch_kind; // Jump, call or any return
  logic skip_taken;
  logic long_now; // Instruction needs a second cycle

  op_decoder i_op_decoder (
    .word(instr_word),
    .dec(dec_now)
  );

  core_alu i_core_alu (
    .kind(dec_reg.kind),
    .a(accum),
    .r(reg_rdata),
    .bit_sel(dec_reg.bit_sel),
    .carry_in(status.carry),
    .dc_in(status.digit_carry),
    .res(alu_res),
    .carry(alu_c),
    .dc(alu_dc)
  );

  // Register-operand classes that may steer the result to the register
  function automatic logic dual_dest(input core_pkg::op_kind_t k);
    dual_dest = (k == core_pkg::subtract_op) || (k == core_pkg::or_op) ||
                (k == core_pkg::decrement_to_accum_op) ||
                (k == core_pkg::and_op) || (k == core_pkg::xor_op);
  endfunction : dual_dest

  // Classes that always write the register file
  function automatic logic reg_only(input core_pkg::op_kind_t k);
    reg_only = (k == core_pkg::store_accum_op) ||
               (k == core_pkg::reg_zero_op) ||
               (k == core_pkg::bit_clear_op) || (k == core_pkg::bit_set_op);
  endfunction : reg_only

  // Destination and timing terms for the instruction in hand
  always_comb
  begin
    exec = (state_reg == core_pkg::st_exec);
    // bit six picks register over accumulator
    to_r = reg_only(dec_reg.kind) || (dual_dest(dec_reg.kind) && dec_reg.to_reg);
    to_a = (dual_dest(dec_reg.kind) && !dec_reg.to_reg) ||
           (dec_reg.kind == core_pkg::accum_zero_op) ||
           (dec_reg.kind == core_pkg::decimal_adjust_op) ||
           (dec_reg.kind == core_pkg::ctrl_reg_read_op) ||
           (dec_reg.kind == core_pkg::return_literal_op);
    zero_upd = dual_dest(dec_reg.kind) ||
               (dec_reg.kind == core_pkg::accum_zero_op) ||
               (dec_reg.kind == core_pkg::reg_zero_op);
    // any write to the program counter register
    pc_write = to_r && (dec_reg.reg_sel == core_pkg::PC_REG_ADDR);
    branch_kind = (dec_reg.kind == core_pkg::jump_op) ||
                  (dec_reg.kind == core_pkg::call_op) ||
                  (dec_reg.kind == core_pkg::return_op) ||
                  (dec_reg.kind == core_pkg::return_from_irq_op) ||
                  (dec_reg.kind == core_pkg::return_literal_op);
    // test one bit of the read register
    skip_taken = ((dec_reg.kind == core_pkg::bit_low_skip_op) &&
                  !reg_rdata[dec_reg.bit_sel]) ||
                 ((dec_reg.kind == core_pkg::bit_high_skip_op) &&
                  reg_rdata[dec_reg.bit_sel]);
    // the select stretches branches and taken skips alike
    long_now = pc_write || (cfg_two_reg && (branch_kind || skip_taken));
  end

  // Sequencer: boot, then fetch/exec pairs, plus a spare cycle when long
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      core_pkg::st_boot: state_next = core_pkg::st_fetch;
      core_pkg::st_fetch: state_next = core_pkg::st_exec;
      // two clock edges per instruction cycle
      core_pkg::st_exec:
        state_next = long_now ? core_pkg::st_extra_a : core_pkg::st_fetch;
      core_pkg::st_extra_a: state_next = core_pkg::st_extra_b;
      core_pkg::st_extra_b: state_next = core_pkg::st_fetch;
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= core_pkg::st_boot;
    else
      state_reg <= state_next;
  end

  // configuration is caught once after reset; no path writes it
  // bit nine chooses one or two cycles for jump and call
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cfg_two_reg <= 1'b0;
    else if (state_reg == core_pkg::st_boot)
      cfg_two_reg <= config_word[core_pkg::CFG_CYCLE_BIT];
  end

  // Latch instruction and present operand addresses during fetch
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      instr_fetch <= 1'b0;
      dec_reg <= core_pkg::decoded_t'(0);
      reg_addr <= 6'h00;
      ctrl_addr <= 4'h0;
    end
    else
    begin
      // High for the whole fetch half-cycle
      instr_fetch <= (state_next == core_pkg::st_fetch);
      if (state_reg == core_pkg::st_fetch)
      begin
        dec_reg <= dec_now;
        // control and general registers share operand decode
        // six-bit designator and four-bit control field
        reg_addr <= dec_now.reg_sel;
        ctrl_addr <= dec_now.reg_sel[3:0];
      end
    end
  end

  // Accumulator updates
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      accum <= core_pkg::ACCUM_RESET;
    else if (exec && to_a)
    begin
      if (dec_reg.kind == core_pkg::ctrl_reg_read_op)
        accum <= ctrl_rdata;
      else if (dec_reg.kind == core_pkg::return_literal_op)
        accum <= dec_reg.literal[7:0];
      else
        accum <= alu_res;
    end
  end

  // Register-file and control-register writes, one pulse each
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_we <= 1'b0;
      reg_wdata <= 8'h00;
      ctrl_we <= 1'b0;
      ctrl_wdata <= 8'h00;
    end
    else
    begin
      // accumulator or ALU result into the register
      reg_we <= exec && to_r;
      if (exec && to_r)
        reg_wdata <= alu_res;
      ctrl_we <= exec && (dec_reg.kind == core_pkg::ctrl_reg_write_op);
      if (exec && (dec_reg.kind == core_pkg::ctrl_reg_write_op))
        ctrl_wdata <= accum;
    end
  end

  // Status flags; untouched unless the class names them
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      status <= core_pkg::STATUS_RESET;
    else if (exec)
    begin
      // zero mirrors the eight-bit result written
      if (zero_upd)
        status.zero <= (alu_res == 8'h00);
      if (dec_reg.kind == core_pkg::decimal_adjust_op)
        status.carry <= alu_c;
      // carry and digit carry on subtract
      if (dec_reg.kind == core_pkg::subtract_op)
      begin
        status.carry <= alu_c;
        status.digit_carry <= alu_dc;
      end
      // both set timeout; power-down tells them apart
      if (dec_reg.kind == core_pkg::halt_oscillator_op)
      begin
        status.timeout <= 1'b1;
        status.power_down <= 1'b0;
      end
      if (dec_reg.kind == core_pkg::watchdog_clear_op)
      begin
        status.timeout <= 1'b1;
        status.power_down <= 1'b1;
      end
    end
  end

  // Interrupt enable level
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_enable <= 1'b0;
    // return from interrupt unmasks as well
    else if (exec && (dec_reg.kind == core_pkg::interrupt_unmask_op ||
                      dec_reg.kind == core_pkg::return_from_irq_op))
      irq_enable <= 1'b1;
    else if (exec && dec_reg.kind == core_pkg::interrupt_mask_op)
      irq_enable <= 1'b0;
  end

  // One-cycle control pulses to the watchdog, clock and sequencer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wdt_clear <= 1'b0;
      osc_stop <= 1'b0;
      stack_pop <= 1'b0;
      call_push <= 1'b0;
      jump_take <= 1'b0;
      jump_target <= 10'h000;
      skip_next <= 1'b0;
      cycle_long <= 1'b0;
    end
    else
    begin
      // halt clears the watchdog and stops the oscillator
      wdt_clear <= exec && (dec_reg.kind == core_pkg::halt_oscillator_op ||
                            dec_reg.kind == core_pkg::watchdog_clear_op);
      osc_stop <= exec && (dec_reg.kind == core_pkg::halt_oscillator_op);
      // every return reloads from the top of stack
      stack_pop <= exec && (dec_reg.kind == core_pkg::return_op ||
                            dec_reg.kind == core_pkg::return_from_irq_op ||
                            dec_reg.kind == core_pkg::return_literal_op);
      call_push <= exec && (dec_reg.kind == core_pkg::call_op);
      jump_take <= exec && (dec_reg.kind == core_pkg::call_op ||
                            dec_reg.kind == core_pkg::jump_op);
      if (exec)
        jump_target <= dec_reg.literal;
      skip_next <= exec && skip_taken;
      cycle_long <= exec && long_now;
    end
  end

  // short instruction refetches after two periods
  property p_short_cycle;
    @(posedge clock) disable iff (rst)
    (exec && !long_now) |=> instr_fetch ##1 !instr_fetch;
  endproperty
  a_short_cycle: assert property (p_short_cycle)
    else $error("short instruction did not refetch after two periods");

  // program counter write holds fetch off a full cycle
  property p_pc_write_long;
    @(posedge clock) disable iff (rst)
    (exec && pc_write) |=> cycle_long ##0 (!instr_fetch)[*2] ##1 instr_fetch;
  endproperty
  a_pc_write_long: assert property (p_pc_write_long)
    else $error("program counter write not two cycles");

  // single-cycle jump when the select is clear
  property p_jump_short;
    @(posedge clock) disable iff (rst)
    (exec && dec_reg.kind == core_pkg::jump_op && !cfg_two_reg)
      |=> jump_take && instr_fetch;
  endproperty
  a_jump_short: assert property (p_jump_short)
    else $error("jump stretched although select is clear");

  // captured configuration never moves after boot
  property p_cfg_fixed;
    @(posedge clock) disable iff (rst)
    (state_reg != core_pkg::st_boot) |=> $stable(cfg_two_reg);
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed)
    else $error("configuration changed during execution");

  // halt pulses, then timeout set and power-down clear
  property p_halt;
    @(posedge clock) disable iff (rst)
    (exec && dec_reg.kind == core_pkg::halt_oscillator_op)
      |=> osc_stop && wdt_clear && status.timeout && !status.power_down;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not stop oscillator or set flags");

  // unmask raises enable and leaves flags alone
  property p_unmask;
    @(posedge clock) disable iff (rst)
    (exec && dec_reg.kind == core_pkg::interrupt_unmask_op)
      |=> irq_enable && $stable(status);
  endproperty
  a_unmask: assert property (p_unmask)
    else $error("unmask failed or disturbed flags");

  // stored value is the accumulator, flags unchanged
  property p_store;
    @(posedge clock) disable iff (rst)
    (exec && dec_reg.kind == core_pkg::store_accum_op)
      |=> reg_we && (reg_wdata == $past(accum)) && $stable(status);
  endproperty
  a_store: assert property (p_store)
    else $error("accumulator store wrong");

  // clear accumulator gives zero and sets the zero flag
  property p_clear_accum;
    @(posedge clock) disable iff (rst)
    (exec && dec_reg.kind == core_pkg::accum_zero_op)
      |=> (accum == 8'h00) && status.zero && !reg_we;
  endproperty
  a_clear_accum: assert property (p_clear_accum)
    else $error("accumulator clear wrong");

  // zero flag tracks the written result
  property p_zero_flag;
    @(posedge clock) disable iff (rst)
    (exec && zero_upd) |=> status.zero == ($past(alu_res) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag does not match result");

  // idle leaves state alone and refetches in one cycle
  property p_idle;
    @(posedge clock) disable iff (rst)
    (exec && dec_reg.kind == core_pkg::idle_op)
      |=> $stable(accum) && $stable(status) && !reg_we && instr_fetch;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle changed state");
endmodule : cpu_instruction_decode_core
`default_nettype wire

// *** src/core_pkg.sv ***
package core_pkg;
  // Word and data widths
  localparam int INSTR_W = 13;
  localparam int DATA_W = 8;
  // Oscillator periods in one instruction cycle
  localparam int OSC_PER_CYCLE = 2;
  // Position of the jump/call cycle select in the configuration word
  localparam int CFG_CYCLE_BIT = 9;
  // Register designator of the program counter
  localparam logic [5:0] PC_REG_ADDR = 6'h02;
  // Fixed control encodings
  localparam logic [12:0] OP_IDLE = 13'h0000;
  localparam logic [12:0] OP_DECIMAL_ADJUST = 13'h0001;
  localparam logic [12:0] OP_HALT = 13'h0003;
  localparam logic [12:0] OP_WDT = 13'h0004;
  localparam logic [12:0] OP_UNMASK = 13'h0010;
  localparam logic [12:0] OP_MASK = 13'h0011;
  localparam logic [12:0] OP_RET = 13'h0012;
  localparam logic [12:0] OP_RETURN_IRQ = 13'h0013;
  localparam logic [12:0] OP_ACCUM_ZERO = 13'h0080;
  // Reset values
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [2:0] CYCLE_CNT_RESET = 3'h0;

  // Operation classes that the decoder can produce
  typedef enum logic [4:0] {
    idle_op, decimal_adjust_op, halt_oscillator_op, watchdog_clear_op,
    ctrl_reg_write_op, ctrl_reg_read_op, interrupt_unmask_op,
    interrupt_mask_op, return_op, return_from_irq_op, store_accum_op,
    accum_zero_op, reg_zero_op, subtract_op, decrement_to_accum_op,
    or_op, and_op, xor_op, bit_clear_op, bit_set_op, bit_low_skip_op,
    bit_high_skip_op, call_op, jump_op, return_literal_op
  } op_kind_t;

  // Core sequencing states
  typedef enum logic [2:0] {
    st_boot, st_fetch, st_exec, st_extra_a, st_extra_b
  } core_state_t;

  // One decoded instruction
  typedef struct packed {
    op_kind_t kind;
    logic to_reg;
    logic [5:0] reg_sel;
    logic [2:0] bit_sel;
    logic [9:0] literal;
  } decoded_t;

  // Status flags kept by the core
  typedef struct packed {
    logic zero;
    logic carry;
    logic digit_carry;
    logic timeout;
    logic power_down;
  } status_t;

  localparam status_t STATUS_RESET = status_t'(5'h00);
endpackage : core_pkg

// *** src/op_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
module op_decoder (
  input wire logic [12:0] word,
  output core_pkg::decoded_t dec
);
  // Field split plus class lookup; unknown codes fall back to idle
  always_comb
  begin
    dec.reg_sel = word[5:0];
    dec.bit_sel = word[8:6];
    dec.literal = word[9:0];
    dec.to_reg = word[6];
    dec.kind = core_pkg::idle_op;
    if (word[12])
    begin
      // Literal group: ten-bit targets and eight-bit constants
      if (word[11:10] == 2'b00)
        dec.kind = core_pkg::call_op;
      else if (word[11:10] == 2'b01)
        dec.kind = core_pkg::jump_op;
      else if (word[11:8] == 4'hc)
        dec.kind = core_pkg::return_literal_op;
    end
    else if (word[11])
    begin
      // Bit group: three-bit position above six-bit register
      case (word[10:9])
        2'b00: dec.kind = core_pkg::bit_clear_op;
        2'b01: dec.kind = core_pkg::bit_set_op;
        2'b10: dec.kind = core_pkg::bit_low_skip_op;
        default: dec.kind = core_pkg::bit_high_skip_op;
      endcase
    end
    else
    begin
      case (word[10:6])
        5'h00:
        begin
          // Exact codes win over the control-register field form
          if (word == core_pkg::OP_IDLE)
            dec.kind = core_pkg::idle_op;
          else if (word == core_pkg::OP_DECIMAL_ADJUST)
            dec.kind = core_pkg::decimal_adjust_op;
          else if (word == core_pkg::OP_HALT)
            dec.kind = core_pkg::halt_oscillator_op;
          else if (word == core_pkg::OP_WDT)
            dec.kind = core_pkg::watchdog_clear_op;
          else if (word[5:4] == 2'b00)
            dec.kind = core_pkg::ctrl_reg_write_op;
          else if (word == core_pkg::OP_UNMASK)
            dec.kind = core_pkg::interrupt_unmask_op;
          else if (word == core_pkg::OP_MASK)
            dec.kind = core_pkg::interrupt_mask_op;
          else if (word == core_pkg::OP_RET)
            dec.kind = core_pkg::return_op;
          else if (word == core_pkg::OP_RETURN_IRQ)
            dec.kind = core_pkg::return_from_irq_op;
          else if (word[5:4] == 2'b01)
            dec.kind = core_pkg::ctrl_reg_read_op;
        end
        5'h01: dec.kind = core_pkg::store_accum_op;
        5'h02: if (word == core_pkg::OP_ACCUM_ZERO) dec.kind = core_pkg::accum_zero_op;
        5'h03: dec.kind = core_pkg::reg_zero_op;
        5'h04, 5'h05: dec.kind = core_pkg::subtract_op;
        5'h06, 5'h07: dec.kind = core_pkg::decrement_to_accum_op;
        5'h08, 5'h09: dec.kind = core_pkg::or_op;
        5'h0a, 5'h0b: dec.kind = core_pkg::and_op;
        5'h0c, 5'h0d: dec.kind = core_pkg::xor_op;
        default: dec.kind = core_pkg::idle_op;
      endcase
    end
  end
endmodule : op_decoder
`default_nettype wire

// *** src/core_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
module core_alu (
  input wire core_pkg::op_kind_t kind,
  input wire logic [7:0] a,
  input wire logic [7:0] r,
  input wire logic [2:0] bit_sel,
  input wire logic carry_in,
  input wire logic dc_in,
  output logic [7:0] res,
  output logic carry,
  output logic dc
);
  // Result and carry terms for one operation
  always_comb
  begin
    logic [8:0] diff;
    logic [4:0] low;
    logic [8:0] adj;
    diff = {1'b0, r} - {1'b0, a};
    low = {1'b0, r[3:0]} - {1'b0, a[3:0]};
    adj = {1'b0, a};
    res = r;
    carry = carry_in;
    dc = dc_in;
    case (kind)
      core_pkg::subtract_op:
      begin
        // Carry means no borrow
        res = diff[7:0];
        carry = ~diff[8];
        dc = ~low[4];
      end
      core_pkg::decrement_to_accum_op: res = r - 8'h01;
      core_pkg::or_op: res = a | r;
      core_pkg::and_op: res = a & r;
      core_pkg::xor_op: res = a ^ r;
      core_pkg::accum_zero_op, core_pkg::reg_zero_op: res = 8'h00;
      core_pkg::store_accum_op: res = a;
      core_pkg::bit_clear_op: res = r & ~(8'h01 << bit_sel);
      core_pkg::bit_set_op: res = r | (8'h01 << bit_sel);
      core_pkg::decimal_adjust_op:
      begin
        // Low digit first, then high digit; only carry is updated
        if (a[3:0] > 4'h9 || dc_in)
          adj = adj + 9'h006;
        if (adj[7:4] > 4'h9 || adj[8] || carry_in)
        begin
          adj = adj + 9'h060;
          carry = 1'b1;
        end
        res = adj[7:0];
      end
      default: res = r;
    endcase
  end
endmodule : core_alu
`default_nettype wire

// *** tb/tb_cpu_instruction_decode_core.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_instruction_decode_core;
  // Inputs driven by the bench
  logic clock;
  logic rst;
  logic [12:0] config_word;
  logic [12:0] instr_word;
  logic [7:0] reg_rdata;
  logic [7:0] ctrl_rdata;
  // Outputs observed by the bench
  logic instr_fetch, reg_we, ctrl_we, irq_enable, wdt_clear, osc_stop;
  logic stack_pop, call_push, jump_take, skip_next, cycle_long;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, ctrl_wdata, accum;
  logic [3:0] ctrl_addr;
  logic [9:0] jump_target;
  core_pkg::status_t status;
  int failures = 0;
  int tests_run = 0;

  cpu_instruction_decode_core i_cpu_instruction_decode_core (
    .clock, .rst, .config_word, .instr_word, .reg_rdata, .ctrl_rdata,
    .instr_fetch, .reg_addr, .reg_wdata, .reg_we, .ctrl_addr, .ctrl_wdata,
    .ctrl_we, .accum, .status, .irq_enable, .wdt_clear, .osc_stop,
    .stack_pop, .call_push, .jump_take, .jump_target, .skip_next,
    .cycle_long
  );

  // Free running 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare a multi-bit result
  task automatic c8(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : c8

  // Compare a single flag or pulse
  task automatic c1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : c1

  // Reset with a chosen jump/call cycle select; config is only read at boot
  task automatic do_reset(input logic sel);
    @(posedge clock);
    rst <= 1'b1;
    config_word <= {3'h7, sel, 9'h1ff};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset

  // Issue one word, then idle behind it so the next fetch is harmless;
  // returns mid result cycle, where pulses stand
  task automatic run(input logic [12:0] w, input logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    instr_word <= w;
    reg_rdata <= rd;
    ctrl_rdata <= rd;
    @(negedge clock);
    while (instr_fetch !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge clock);
    end
    c1(instr_fetch, 1'b1);
    @(posedge clock);
    @(posedge clock);
    instr_word <= core_pkg::OP_IDLE;
    @(negedge clock);
  endtask : run

  // Subtract and decrement flag behaviour
  task automatic t_arith;
    run(13'h0185, 8'h10); c8(accum, 8'h0f); c1(reg_we, 1'b0);
    run(13'h0105, 8'h05); c8(accum, 8'hf6); c8(status, 5'h00);
    run(13'h0145, 8'hf6); c8(reg_wdata, 8'h00); c8(status, 5'h1c);
    c1(reg_we, 1'b1); c8(accum, 8'hf6);
    run(13'h01c9, 8'h01); c8(reg_wdata, 8'h00); c8(reg_addr, 6'h09);
    c8(status, 5'h1c);
  endtask : t_arith

  // Logic group with both destinations
  task automatic t_logic;
    run(13'h0203, 8'h09); c8(accum, 8'hff); c8(status, 5'h0c);
    run(13'h02c3, 8'h00); c8(reg_wdata, 8'h00); c8(accum, 8'hff);
    c8(status, 5'h1c);
    run(13'h0303, 8'hff); c8(accum, 8'h00); c1(reg_we, 1'b0);
  endtask : t_logic

  // Moves, clears, bit ops and an undefined word
  task automatic t_move;
    run(13'h0017, 8'h5a); c8(accum, 8'h5a); c8(status, 5'h1c);
    run(13'h0005, 8'h00); c1(ctrl_we, 1'b1); c8(ctrl_addr, 4'h5);
    c8(ctrl_wdata, 8'h5a);
    run(13'h0047, 8'h00); c8(reg_wdata, 8'h5a); c1(cycle_long, 1'b0);
    c8(reg_addr, 6'h07); c8(status, 5'h1c);
    run(13'h0042, 8'h00); c1(cycle_long, 1'b1); c1(reg_we, 1'b1);
    run(13'h0203, 8'h00); run(13'h0080, 8'h00);
    c8(accum, 8'h00); c8(status, 5'h1c);
    run(13'h0025, 8'hff); c8(accum, 8'h00); c1(ctrl_we, 1'b0);
    c1(reg_we, 1'b0); c1(cycle_long, 1'b0);
    run(13'h0ac4, 8'h00); c8(reg_wdata, 8'h08);
    run(13'h09c4, 8'hff); c8(reg_wdata, 8'h7f);
  endtask : t_move

  // Interrupt mask, interrupt return, halt and watchdog clear
  task automatic t_ctrl;
    run(13'h0010, 8'h00); c1(irq_enable, 1'b1);
    run(13'h0011, 8'h00); c1(irq_enable, 1'b0); c1(stack_pop, 1'b0);
    run(13'h0013, 8'h00); c1(irq_enable, 1'b1); c1(stack_pop, 1'b1);
    run(13'h0003, 8'h00); c1(osc_stop, 1'b1); c8(status, 5'h1e);
    run(13'h0004, 8'h00); c1(osc_stop, 1'b0); c1(wdt_clear, 1'b1);
    c8(status, 5'h1f);
    run(13'h0001, 8'h00); c8(accum, 8'h66); c8(status, 5'h1f);
  endtask : t_ctrl

  // Branch length follows the select captured at boot
  task automatic t_cycle(input logic sel);
    run(13'h16a5, 8'h00); c8(jump_target, 10'h2a5); c1(cycle_long, sel);
    c1(jump_take, 1'b1); c1(instr_fetch, !sel);
    run(13'h1155, 8'h00); c1(call_push, 1'b1); c1(cycle_long, sel);
    run(13'h0012, 8'h00); c1(stack_pop, 1'b1); c1(cycle_long, sel);
    run(13'h1c3c, 8'h00); c8(accum, 8'h3c); c1(stack_pop, 1'b1);
    c1(cycle_long, sel);
    run(13'h0e83, 8'h04); c1(skip_next, 1'b1); c1(cycle_long, sel);
    run(13'h0c83, 8'h04); c1(skip_next, 1'b0); c1(cycle_long, 1'b0);
  endtask : t_cycle

  // Verdict and end of run
  task automatic report_and_stop;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    rst = 1'b1;
    config_word = 13'h1dff;
    instr_word = 13'h0000;
    reg_rdata = 8'h00;
    ctrl_rdata = 8'h00;
    do_reset(1'b0);
    @(negedge clock);
    c8(accum, 8'h00); c8(status, 5'h00);
    t_arith();
    t_logic();
    t_move();
    t_ctrl();
    t_cycle(1'b0);
    do_reset(1'b1);
    t_cycle(1'b1);
    report_and_stop();
  end

  // Hang guard, far beyond the two hundred or so cycles the tests need
  initial
  begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule : tb_cpu_instruction_decode_core
`default_nettype wire
